// ===== rtl/ifw_identify_words.v
// What this block does
// - Link support word: bits 1-6 features, rest zero
// - Link enabled word mirrors positions, bit 0 zero
// - Support words B,C: bit 14 one, 15 zero
// - Reserved support bits read zero
// - Support A fixed ones and zeros
// - Support A security, cache, look-ahead from capability
// - Support B bit 3 shows APM capability
// - Support B bits 0,1,2,4 read zero
// - Enabled C: bit 14 one, rest zero
// - Enabled A security, cache, look-ahead live state
// - Enabled A fixed bits mirror support A
// - Enabled B bit 3 shows APM enabled
// - At most one DMA mode selected
// - UDMA bits 14:8 one-hot selected mode, all zero when UDMA not selected
// - UDMA supported bits are cumulative
// - No UDMA support gives zero word
// - Erase time word is minutes divided by two
`timescale 1ns/100ps
`include "ifw_map.vh"

module ifw_identify_words #(
    parameter [5:0] LINK_FEAT_SUP   = 6'h3F,
    parameter       SEC_SUPPORTED   = 1,
    parameter       WCACHE_SUPPORTED = 1,
    parameter       LOOKAHEAD_SUPPORTED = 1,
    parameter       APM_SUPPORTED   = 1,
    parameter       UDMA_SUPPORTED  = 1,
    parameter [2:0] UDMA_MAX_MODE   = 3'h6,
    parameter [15:0] ERASE_MINUTES  = 16'h003C
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        rd_req,
    input  wire [7:0]  rd_word_index,
    input  wire [5:0]  link_feat_enabled,
    input  wire        security_enabled,
    input  wire        wcache_enabled,
    input  wire        lookahead_enabled,
    input  wire        apm_enabled,
    input  wire        udma_selected,
    input  wire [2:0]  udma_mode,
    output reg  [15:0] rd_data,
    output reg         rd_valid,
    output reg         rd_hit
);

    reg  [5:0]  link_en_sync1_reg;
    reg  [5:0]  link_en_sync2_reg;
    reg  [4:0]  cfg_sync1_reg;
    reg  [4:0]  cfg_sync2_reg;
    reg  [2:0]  mode_sync1_reg;
    reg  [2:0]  mode_sync2_reg;

    // Config may come from firmware on another clock; two stages each
    always @(posedge core_clk) begin
        if (rst) begin
            link_en_sync1_reg <= 6'h00;
            link_en_sync2_reg <= 6'h00;
            cfg_sync1_reg     <= 5'h00;
            cfg_sync2_reg     <= 5'h00;
            mode_sync1_reg    <= 3'h0;
            mode_sync2_reg    <= 3'h0;
        end else begin
            link_en_sync1_reg <= link_feat_enabled;
            link_en_sync2_reg <= link_en_sync1_reg;
            cfg_sync1_reg     <= {udma_selected, apm_enabled, lookahead_enabled, wcache_enabled, security_enabled};
            cfg_sync2_reg     <= cfg_sync1_reg;
            mode_sync1_reg    <= udma_mode;
            mode_sync2_reg    <= mode_sync1_reg;
        end
    end

    wire sec_en  = cfg_sync2_reg[0];
    wire wc_en   = cfg_sync2_reg[1];
    wire la_en   = cfg_sync2_reg[2];
    wire apm_en  = cfg_sync2_reg[3];
    wire udma_on = cfg_sync2_reg[4];

    wire sec_cap = (SEC_SUPPORTED != 0);
    wire wc_cap  = (WCACHE_SUPPORTED != 0);
    wire la_cap  = (LOOKAHEAD_SUPPORTED != 0);
    wire apm_cap = (APM_SUPPORTED != 0);

    reg  [15:0] w_link_sup;
    reg  [15:0] w_link_en;
    reg  [15:0] w_sup_a;
    reg  [15:0] w_sup_b;
    reg  [15:0] w_sup_c;
    reg  [15:0] w_en_a;
    reg  [15:0] w_en_b;
    reg  [15:0] w_en_c;
    reg  [15:0] w_udma;
    reg  [15:0] w_erase;
    reg  [6:0]  udma_sup_bits;
    reg  [6:0]  udma_sel_bits;
    reg  [2:0]  sel_mode;
    reg  [15:0] rd_data_next;
    reg         rd_hit_next;
    integer     i;

    always @* begin
        w_link_sup = {9'h000, LINK_FEAT_SUP, 1'b0};
        // Enabled only where supported; bit 0 forced low
        w_link_en  = {9'h000, link_en_sync2_reg & LINK_FEAT_SUP, 1'b0};

        w_sup_a = `IFW_RESET_WORD;
        w_sup_a[`IFW_BIT_PWR_MGMT] = 1'b1;
        w_sup_a[`IFW_BIT_WR_BUF]   = 1'b1;
        w_sup_a[`IFW_BIT_RD_BUF]   = 1'b1;
        w_sup_a[`IFW_BIT_NOP]      = 1'b1;
        w_sup_a[`IFW_BIT_SECURITY]  = sec_cap;
        w_sup_a[`IFW_BIT_WCACHE]    = wc_cap;
        w_sup_a[`IFW_BIT_LOOKAHEAD] = la_cap;

        w_sup_b = `IFW_VALID_WORD;
        w_sup_b[`IFW_BIT_APM] = apm_cap;
        w_sup_c = `IFW_VALID_WORD;

        w_en_a = `IFW_RESET_WORD;
        w_en_a[`IFW_BIT_PWR_MGMT] = 1'b1;
        w_en_a[`IFW_BIT_WR_BUF]   = 1'b1;
        w_en_a[`IFW_BIT_RD_BUF]   = 1'b1;
        w_en_a[`IFW_BIT_NOP]      = 1'b1;
        // A feature cannot read enabled unless it is supported
        w_en_a[`IFW_BIT_SECURITY]  = sec_cap & sec_en;
        w_en_a[`IFW_BIT_WCACHE]    = wc_cap & wc_en;
        w_en_a[`IFW_BIT_LOOKAHEAD] = la_cap & la_en;

        w_en_b = `IFW_RESET_WORD;
        w_en_b[`IFW_BIT_APM] = apm_cap & apm_en;
        w_en_c = `IFW_VALID_WORD;

        // Selection clamps to the top supported mode
        sel_mode = (mode_sync2_reg > UDMA_MAX_MODE) ? UDMA_MAX_MODE : mode_sync2_reg;
        for (i = 0; i < 7; i = i + 1) begin
            udma_sup_bits[i] = (i <= UDMA_MAX_MODE);
            udma_sel_bits[i] = udma_on && (sel_mode == i);
        end
        if (UDMA_SUPPORTED != 0) begin
            w_udma = {1'b0, udma_sel_bits, 1'b0, udma_sup_bits};
        end else begin
            w_udma = `IFW_RESET_WORD;
        end

        w_erase = ERASE_MINUTES / `IFW_ERASE_UNIT_MIN;

        rd_hit_next = 1'b1;
        case (rd_word_index)
            `IFW_OFS_LINK_SUP:   rd_data_next = w_link_sup;
            `IFW_OFS_LINK_EN:    rd_data_next = w_link_en;
            `IFW_OFS_CMD_SUP_A:  rd_data_next = w_sup_a;
            `IFW_OFS_CMD_SUP_B:  rd_data_next = w_sup_b;
            `IFW_OFS_CMD_SUP_C:  rd_data_next = w_sup_c;
            `IFW_OFS_CMD_EN_A:   rd_data_next = w_en_a;
            `IFW_OFS_CMD_EN_B:   rd_data_next = w_en_b;
            `IFW_OFS_CMD_EN_C:   rd_data_next = w_en_c;
            `IFW_OFS_UDMA:       rd_data_next = w_udma;
            `IFW_OFS_ERASE_TIME: rd_data_next = w_erase;
            default: begin
                rd_data_next = `IFW_RESET_WORD;
                rd_hit_next  = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            rd_data  <= `IFW_RESET_WORD;
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            rd_hit   <= rd_req & rd_hit_next;
            rd_data  <= rd_req ? rd_data_next : `IFW_RESET_WORD;
        end
    end

endmodule // ifw_identify_words

// ===== shared/ifw_map.vh
`ifndef IFW_MAP_VH
`define IFW_MAP_VH

// Word indices within the identification block
`define IFW_OFS_LINK_SUP   8'h4E
`define IFW_OFS_LINK_EN    8'h4F
`define IFW_OFS_CMD_SUP_A  8'h52
`define IFW_OFS_CMD_SUP_B  8'h53
`define IFW_OFS_CMD_SUP_C  8'h54
`define IFW_OFS_CMD_EN_A   8'h55
`define IFW_OFS_CMD_EN_B   8'h56
`define IFW_OFS_CMD_EN_C   8'h57
`define IFW_OFS_UDMA       8'h58
`define IFW_OFS_ERASE_TIME 8'h59

// Field positions
`define IFW_BIT_SECURITY   1
`define IFW_BIT_PWR_MGMT   3
`define IFW_BIT_WCACHE     5
`define IFW_BIT_LOOKAHEAD  6
`define IFW_BIT_WR_BUF     12
`define IFW_BIT_RD_BUF     13
`define IFW_BIT_NOP        14
`define IFW_BIT_APM        3
`define IFW_BIT_VALID_ONE  14
`define IFW_BIT_VALID_ZERO 15
`define IFW_UDMA_SEL_LSB   8

// Fixed values
`define IFW_VALID_WORD     16'h4000
`define IFW_RESET_WORD     16'h0000
`define IFW_ERASE_UNIT_MIN 16'h0002

// Read latency from address to data, in clock cycles
`define IFW_READ_LATENCY   1

`endif

// ===== dv/ifw_words_properties.sv
`timescale 1ns/100ps
module ifw_words_checker (
    input wire        core_clk,
    input wire        rst,
    input wire        rd_req,
    input wire [7:0]  rd_word_index,
    input wire [15:0] rd_data,
    input wire        rd_valid,
    input wire        rd_hit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence rd_of(logic [7:0] w);
        rd_req && rd_word_index == w;
    endsequence
    answer_latency_a: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
    quiet_idle_a: assert property (!rd_req |=> !rd_valid && rd_data == 16'h0000)
        else $error("output without request");
    link_reserved_a: assert property (rd_req && rd_word_index[7:1] == 7'h27 |=> rd_data[15:7] == 9'h000
        && !rd_data[0]) else $error("link word reserved bits set");
    supa_fixed_a: assert property (rd_of(8'h52) |=> (rd_data & 16'h779D) == 16'h7008)
        else $error("support A fixed bits wrong");
    ena_fixed_a: assert property (rd_of(8'h55) |=> (rd_data & 16'h779D) == 16'h7008)
        else $error("enabled A fixed bits wrong");
    supb_fixed_a: assert property (rd_of(8'h53) |=> (rd_data & 16'hFFF7) == 16'h4000)
        else $error("support B fixed bits wrong");
    valid_marker_a: assert property (rd_of(8'h54) or rd_of(8'h57) |=> rd_data == 16'h4000)
        else $error("marker word wrong");
    udma_onehot_a: assert property (rd_of(8'h58) |=> $onehot0(rd_data[14:8]) && rd_data[6:0] == 7'h7F)
        else $error("udma word malformed");
endmodule // ifw_words_checker

bind ifw_identify_words ifw_words_checker i_ifw_words_checker (.core_clk(core_clk), .rst(rst), .rd_req(rd_req),
    .rd_word_index(rd_word_index), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));

// ===== dv/ifw_host_model.sv
`timescale 1ns/100ps
module ifw_host_model (
    input  wire        core_clk,
    output reg         rd_req,
    output reg  [7:0]  rd_word_index,
    input  wire [15:0] rd_data,
    input  wire        rd_valid,
    input  wire        rd_hit
);
    reg known;
    initial begin
        rd_req = 1'b0;
        rd_word_index = 8'h00;
        known = 1'b0;
    end
    // Index held until the answer is captured, then scrambled
    task rd(input [7:0] w, output [15:0] d, output h, output v);
        begin
            @(negedge core_clk);
            rd_req = 1'b1;
            rd_word_index = w;
            @(negedge core_clk);
            d = rd_data;
            h = rd_hit;
            v = rd_valid;
            known = v && d !== 16'h0000 && d !== 16'hFFFF;
            rd_req = 1'b0;
            rd_word_index = ~w;
        end
    endtask
endmodule // ifw_host_model

// ===== dv/identify_feature_words_test.sv
`timescale 1ns/100ps
module identify_feature_words_test;
    reg         core_clk, rst, sec, wc, la, apm, usel, h, v;
    reg  [5:0]  lfe;
    reg  [2:0]  umode;
    reg  [15:0] d;
    wire        rd_req, rd_valid, rd_hit;
    wire [7:0]  idx;
    wire [15:0] rd_data;
    integer     err_total, n_tests, i, r;
    ifw_identify_words i_ifw_identify_words (.core_clk(core_clk), .rst(rst), .rd_req(rd_req),
        .rd_word_index(idx), .link_feat_enabled(lfe), .security_enabled(sec), .wcache_enabled(wc),
        .lookahead_enabled(la), .apm_enabled(apm), .udma_selected(usel), .udma_mode(umode),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
    ifw_host_model i_ifw_host_model (.core_clk(core_clk), .rd_req(rd_req), .rd_word_index(idx),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
    function [15:0] exp_word(input integer w);
        begin
            case (w)
                8'h4E: exp_word = 16'h007E;
                8'h4F: exp_word = {9'h000, lfe, 1'b0};
                8'h52: exp_word = 16'h706A;
                8'h53: exp_word = 16'h4008;
                8'h54, 8'h57: exp_word = 16'h4000;
                8'h55: exp_word = 16'h7008 | (sec << 1) | (wc << 5) | (la << 6);
                8'h56: exp_word = apm << 3;
                8'h58: exp_word = 16'h007F | (usel << (8 + ((umode > 6) ? 6 : umode)));
                8'h59: exp_word = 60 / 2;
                default: exp_word = 16'h0000;
            endcase
        end
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("Checks %0d, errors %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        err_total = err_total + 1;
        close_out;
    end
    initial begin
        err_total = 0;
        n_tests = 0;
        rst = 1'b1;
        {sec, wc, la, apm, usel, umode, lfe} = 14'h0000;
        r = $urandom(32'h5828);
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        for (i = 0; i < 40; i = i + 1) begin
            // Config settles through the input synchronisers first
            {sec, wc, la, apm, usel, umode, lfe} = $urandom;
            repeat (3) @(negedge core_clk);
            for (r = 8'h4D; r < 8'h5B; r = r + 1) begin
                i_ifw_host_model.rd(r[7:0], d, h, v);
                chk(d, exp_word(r));
                chk({14'h0000, v, h}, {14'h0001, r == 8'h4E || r == 8'h4F || r > 8'h51 && r < 8'h5A});
                if (r == 8'h52 || r == 8'h53 || r == 8'h54 || r == 8'h57)
                    chk({15'h0000, i_ifw_host_model.known}, 16'h0001);
            end
        end
        close_out;
    end
endmodule // identify_feature_words_test
